// >>> rtl/switch_diag.sv
// One channel of retry, diagnostic flag and sense selection logic
`include "switch_diag_consts.svh"
`timescale 1ns/1ps
module switch_diag #(
  parameter int unsigned ON_OPEN_LOAD_FLAG_PERIOD = `ON_OPEN_LOAD_FLAG_PERIOD_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_load_motor,
  input wire logic i_retry_sel,
  input wire logic i_unlimited,
  input wire logic i_failsafe_enter,
  input wire logic i_sleep_exit,
  input wire logic i_por,
  input wire logic i_retry_event,
  input wire logic i_latch_event,
  input wire logic [8:0] i_channel_config_register,
  input wire logic i_low_current_ratio,
  input wire logic i_fast_slew,
  input wire logic i_internal_pwm,
  input wire logic i_pwm_on,
  input wire logic i_direct_in_pin,
  input wire logic i_oc_seen,
  input wire logic i_oc_window,
  input wire logic i_cmp_short_pin,
  input wire logic i_cmp_off_open_pin,
  input wire logic i_cmp_on_open_pin,
  input wire logic i_fault_read,
  input wire logic i_sense_select_a,
  input wire logic i_sense_select_b,
  input wire logic i_track_hold,
  output logic o_channel_on,
  output logic o_fault_pin_n,
  output logic o_supply_short_flag,
  output logic o_off_open_load_flag,
  output logic o_on_open_load_flag,
  output logic [2:0] o_read_data,
  output logic o_oc_duration_restart,
  output logic o_retry_exhausted,
  output logic [3:0] o_retry_count,
  output logic o_delatch,
  output logic [1:0] o_sense_source,
  output logic o_sense_enable,
  output logic o_sense_hold,
  output logic o_sense_sync_pin,
  output logic o_high_current_ratio,
  output logic o_low_oc_threshold
);
  logic dir_in;
  logic cmp_short;
  logic cmp_off_open;
  logic cmp_on_open;
  logic retry_enabled;
  logic delatch;
  logic exhausted;
  logic [3:0] count;
  logic on_nxt;
  logic on_prev_r;
  logic turn_off;
  logic short_det;
  logic off_open_det;
  logic on_open_cont;
  logic on_open_event;
  logic on_open_event_fault;
  logic [31:0] on_open_load_flag_timer_r;
  logic on_open_load_flag_due_r;
  logic [31:0] on_run_r;
  logic on_run_full;
  logic clean_event_r;
  logic period_clean_r;
  logic os_dis;
  logic oloff_dis;
  logic on_open_load_flag_dis;
  logic dir_dis;
  switch_diag_pkg::sense_src_type src;

  pin_sync u_sync_dir (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_pin(i_direct_in_pin),
    .o_level(dir_in)
  );

  pin_sync u_sync_os (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_pin(i_cmp_short_pin),
    .o_level(cmp_short)
  );

  pin_sync u_sync_off (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_pin(i_cmp_off_open_pin),
    .o_level(cmp_off_open)
  );

  pin_sync u_sync_on (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_pin(i_cmp_on_open_pin),
    .o_level(cmp_on_open)
  );

  // Retry count, its clear events and the delatch request
  retry_counter u_retry (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_load_motor(i_load_motor),
    .i_retry_sel(i_retry_sel),
    .i_unlimited(i_unlimited),
    .i_failsafe_enter(i_failsafe_enter),
    .i_sleep_exit(i_sleep_exit),
    .i_por(i_por),
    .i_retry_event(i_retry_event),
    .i_latch_event(i_latch_event),
    .o_retry_enabled(retry_enabled),
    .o_clear(),
    .o_delatch(delatch),
    .o_exhausted(exhausted),
    .o_count(count)
  );

  assign os_dis = i_channel_config_register[`CFG_OS_DIS];
  assign oloff_dis = i_channel_config_register[`CFG_OLOFF_DIS];
  assign on_open_load_flag_dis = i_channel_config_register[`CFG_ON_OPEN_LOAD_FLAG_DIS];
  assign dir_dis = i_channel_config_register[`CFG_DIR_DIS];

  // Channel state: internal PWM, or direct input unless disabled
  assign on_nxt = i_internal_pwm ? i_pwm_on : (dir_in && !dir_dis);
  assign turn_off = on_prev_r && !on_nxt;

  // Detections; none of them touches the channel state
  assign short_det = !on_nxt && cmp_short && !os_dis;
  assign off_open_det = !on_nxt && cmp_off_open && !oloff_dis;
  assign on_open_cont = !i_low_current_ratio && on_nxt && cmp_on_open && !on_open_load_flag_dis;
  // Low ratio sampled check, fast slew only
  // Full-duty PWM has no turn-off edge; a long on run stands in for it
  assign on_open_event = i_low_current_ratio && i_fast_slew && !on_open_load_flag_dis
                         && (i_internal_pwm ? (on_open_load_flag_due_r && (turn_off || on_run_full))
                                            : turn_off);
  assign on_open_event_fault = on_open_event && cmp_on_open;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      on_prev_r <= 1'b0;
      o_channel_on <= 1'b0;
    end else begin
      on_prev_r <= on_nxt;
      o_channel_on <= on_nxt;
    end
  end

  // Minimum spacing timer for internal PWM low ratio checks
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      on_open_load_flag_timer_r <= 32'h0;
      on_open_load_flag_due_r <= 1'b0;
    end else if (on_open_event) begin
      on_open_load_flag_timer_r <= 32'h0;
      on_open_load_flag_due_r <= 1'b0;
    end else if (on_open_load_flag_timer_r >= ON_OPEN_LOAD_FLAG_PERIOD - 1) begin
      on_open_load_flag_due_r <= 1'b1;
    end else begin
      on_open_load_flag_timer_r <= on_open_load_flag_timer_r + 32'h1;
    end
  end

  // Continuous on time, so full-duty PWM still gets its periodic check
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      on_run_r <= 32'h0;
    end else if (!on_nxt) begin
      on_run_r <= 32'h0;
    end else if (on_run_r < ON_OPEN_LOAD_FLAG_PERIOD - 1) begin
      on_run_r <= on_run_r + 32'h1;
    end
  end

  assign on_run_full = (on_run_r >= ON_OPEN_LOAD_FLAG_PERIOD - 1);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      clean_event_r <= 1'b0;
    end else if (on_open_event) begin
      clean_event_r <= !cmp_on_open;
    end else if (i_fault_read) begin
      clean_event_r <= 1'b0;
    end
  end

  // Read returns the held flags, the clear lands after; a new set wins
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_read_data <= 3'h0;
    end else if (i_fault_read) begin
      o_read_data <= {o_on_open_load_flag, o_off_open_load_flag, o_supply_short_flag};
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_supply_short_flag <= 1'b0;
    end else if (short_det) begin
      o_supply_short_flag <= 1'b1;
    end else if (i_fault_read) begin
      o_supply_short_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_off_open_load_flag <= 1'b0;
    end else if (off_open_det) begin
      o_off_open_load_flag <= 1'b1;
    end else if (i_fault_read) begin
      o_off_open_load_flag <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_on_open_load_flag <= 1'b0;
    end else if (on_open_cont || on_open_event_fault) begin
      o_on_open_load_flag <= 1'b1;
    end else if (i_fault_read) begin
      if (i_low_current_ratio) begin
        if (clean_event_r) begin
          o_on_open_load_flag <= 1'b0;
        end
      end else if (!on_nxt || !cmp_on_open) begin
        o_on_open_load_flag <= 1'b0;
      end
    end
  end

  // Fault pin follows live causes, registered one cycle after detection
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fault_pin_n <= 1'b1;
    end else begin
      o_fault_pin_n <= !(short_det || off_open_det || on_open_cont || on_open_event_fault);
    end
  end

  // Motor: remembers whether the current PWM period was overcurrent free
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      period_clean_r <= 1'b1;
    end else if (turn_off || (!on_prev_r && on_nxt)) begin
      period_clean_r <= 1'b1;
    end else if (i_oc_seen) begin
      period_clean_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_oc_duration_restart <= 1'b0;
    end else if (i_load_motor) begin
      o_oc_duration_restart <= turn_off && period_clean_r && !i_oc_seen;
    end else begin
      o_oc_duration_restart <= i_retry_event;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_retry_exhausted <= 1'b0;
      o_retry_count <= 4'h0;
      o_delatch <= 1'b0;
    end else begin
      o_retry_exhausted <= exhausted;
      o_retry_count <= count;
      o_delatch <= delatch && retry_enabled;
    end
  end

  always_comb begin
    case ({i_sense_select_b, i_sense_select_a})
      `SENSE_SEL_CH0: src = switch_diag_pkg::src_ch0;
      `SENSE_SEL_CH1: src = switch_diag_pkg::src_ch1;
      `SENSE_SEL_TEMP: src = switch_diag_pkg::src_temp;
      default: src = switch_diag_pkg::src_none;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sense_source <= 2'h0;
      o_sense_enable <= 1'b0;
      o_sense_hold <= 1'b0;
      o_sense_sync_pin <= 1'b1;
      o_high_current_ratio <= 1'b1;
      o_low_oc_threshold <= 1'b0;
    end else begin
      o_sense_source <= src;
      o_sense_enable <= !i_oc_window && (on_nxt || i_track_hold);
      o_sense_hold <= i_track_hold && !on_nxt;
      o_sense_sync_pin <= i_oc_window || !on_nxt;
      o_high_current_ratio <= !i_low_current_ratio;
      o_low_oc_threshold <= i_low_current_ratio;
    end
  end
endmodule

// >>> rtl/switch_diag_consts.svh
// Constants for the switch retry and diagnostics block
`ifndef SWITCH_DIAG_CONSTS_SVH
`define SWITCH_DIAG_CONSTS_SVH
`define CLK_PERIOD_NS 5
`define ON_OPEN_LOAD_FLAG_PERIOD_MS 150
`define ON_OPEN_LOAD_FLAG_PERIOD_CYC ((`ON_OPEN_LOAD_FLAG_PERIOD_MS * 1000000) / `CLK_PERIOD_NS)
`define RETRY_MAX 4'hf
`define CFG_DIR_DIS 5
`define CFG_OS_DIS 6
`define CFG_OLOFF_DIS 7
`define CFG_ON_OPEN_LOAD_FLAG_DIS 8
`define SENSE_SEL_OFF 2'h0
`define SENSE_SEL_CH0 2'h1
`define SENSE_SEL_CH1 2'h2
`define SENSE_SEL_TEMP 2'h3
`endif

// >>> rtl/switch_diag_pkg.sv
// Types for the switch retry and diagnostics block
package switch_diag_pkg;
  typedef enum logic [1:0] {
    src_none,
    src_ch0,
    src_ch1,
    src_temp
  } sense_src_type;
endpackage

// >>> rtl/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_level <= 1'b0;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end
endmodule

// >>> rtl/retry_counter.sv
// Per-channel auto-retry counter with clear events and delatch
`include "switch_diag_consts.svh"
`timescale 1ns/1ps
module retry_counter (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_load_motor,
  input wire logic i_retry_sel,
  input wire logic i_unlimited,
  input wire logic i_failsafe_enter,
  input wire logic i_sleep_exit,
  input wire logic i_por,
  input wire logic i_retry_event,
  input wire logic i_latch_event,
  output logic o_retry_enabled,
  output logic o_clear,
  output logic o_delatch,
  output logic o_exhausted,
  output logic [3:0] o_count
);
  logic sel_prev_r;
  logic unl_prev_r;
  logic latched_r;
  logic retry_dis_edge;
  logic unl_rise;

  assign o_retry_enabled = i_load_motor ? i_retry_sel : !i_retry_sel;
  assign retry_dis_edge = i_load_motor ? (sel_prev_r && !i_retry_sel) : (!sel_prev_r && i_retry_sel);
  assign unl_rise = i_unlimited && !unl_prev_r;
  assign o_clear = i_failsafe_enter || i_sleep_exit || i_por || unl_rise || retry_dis_edge;
  assign o_delatch = unl_rise && latched_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sel_prev_r <= 1'b0;
      unl_prev_r <= 1'b0;
    end else begin
      sel_prev_r <= i_retry_sel;
      unl_prev_r <= i_unlimited;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= 4'h0;
      o_exhausted <= 1'b0;
      latched_r <= 1'b0;
    end else if (o_clear) begin
      o_count <= 4'h0;
      o_exhausted <= 1'b0;
      if (o_delatch) begin
        latched_r <= 1'b0;
      end
    end else begin
      if (i_retry_event && o_retry_enabled && !i_unlimited) begin
        if (o_count == `RETRY_MAX) begin
          o_exhausted <= 1'b1;
        end else begin
          o_count <= o_count + 4'h1;
        end
      end
      if (i_latch_event && !i_unlimited) begin
        latched_r <= 1'b1;
      end
    end
  end
endmodule

// >>> dv/load_model.sv
// Switched load model that drives the three diagnostic comparators
`timescale 1ns/1ps
module load_model (
  input wire logic i_on,
  input wire logic [1:0] i_fault,
  output logic o_short,
  output logic o_off_open,
  output logic o_on_open
);
  // Bit 0 shorts the output to supply, bit 1 disconnects the load
  assign o_short = i_fault[0] & !i_on;
  assign o_off_open = i_fault[1] & !i_on;
  assign o_on_open = i_fault[1] & i_on;
endmodule

// >>> dv/switch_diag_assertions.sv
// Concurrent checks on the ports of one switch diagnostics channel
`timescale 1ns/1ps
module switch_diag_checker #(
  parameter int unsigned ON_OPEN_LOAD_FLAG_PERIOD = 50
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_load_motor,
  input wire logic i_failsafe_enter,
  input wire logic i_sleep_exit,
  input wire logic i_por,
  input wire logic i_retry_event,
  input wire logic [8:0] i_channel_config_register,
  input wire logic i_low_current_ratio,
  input wire logic i_oc_window,
  input wire logic i_cmp_short_pin,
  input wire logic i_fault_read,
  input wire logic o_channel_on,
  input wire logic o_fault_pin_n,
  input wire logic o_supply_short_flag,
  input wire logic o_off_open_load_flag,
  input wire logic o_oc_duration_restart,
  input wire logic o_retry_exhausted,
  input wire logic [3:0] o_retry_count,
  input wire logic o_sense_enable,
  input wire logic o_sense_sync_pin,
  input wire logic o_high_current_ratio,
  input wire logic o_low_oc_threshold
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);
  sequence s_short_held;
    (i_cmp_short_pin && !o_channel_on && !i_channel_config_register[6]) [*8];
  endsequence
  sequence s_short_masked;
    i_channel_config_register[6] [*8];
  endsequence
  a_short_sets_flag: assert property (s_short_held |=> o_supply_short_flag && !o_fault_pin_n)
    else $error("short while off did not raise flag and pin");
  a_short_masked: assert property (s_short_masked |=> !$rose(o_supply_short_flag))
    else $error("short flag rose while disabled");
  a_short_sticky: assert property ($fell(o_supply_short_flag) |-> $past(i_fault_read) || $past(i_fault_read, 2))
    else $error("short flag cleared without read");
  a_offopen_sticky: assert property ($fell(o_off_open_load_flag) |-> $past(i_fault_read) || $past(i_fault_read, 2))
    else $error("off open flag cleared without read");
  a_oc_window_sense: assert property (i_oc_window |=> !o_sense_enable && o_sense_sync_pin)
    else $error("sensing active in overcurrent window");
  a_ratio_follow: assert property (1'h1 |=> o_low_oc_threshold == $past(i_low_current_ratio)
    && o_high_current_ratio != $past(i_low_current_ratio))
    else $error("ratio outputs do not follow ratio bit");
  a_retry_clear: assert property ((i_por || i_failsafe_enter || i_sleep_exit) |-> ##2 o_retry_count == 4'h0)
    else $error("retry count not cleared");
  a_light_restart: assert property (i_retry_event && !i_load_motor |-> ##[1:2] o_oc_duration_restart)
    else $error("no duration restart after lighting retry");
  a_exhaust_at_max: assert property ($rose(o_retry_exhausted) |-> $past(o_retry_count) == 4'hf)
    else $error("exhausted set below full count");
endmodule
bind switch_diag switch_diag_checker #(.ON_OPEN_LOAD_FLAG_PERIOD(ON_OPEN_LOAD_FLAG_PERIOD)) i_chk (.*);

// >>> dv/switch_diag_tb.sv
// Self-checking bench for one switch diagnostics channel
`timescale 1ns/1ps
module switch_diag_tb;
  logic i_clock = 1'h0, i_nrst = 1'h0, i_load_motor = 1'h0, i_retry_sel = 1'h0, i_unlimited = 1'h0;
  logic i_failsafe_enter = 1'h0, i_sleep_exit = 1'h0, i_por = 1'h0, i_retry_event = 1'h0, i_latch_event = 1'h0;
  logic [8:0] i_channel_config_register = 9'h0;
  logic i_low_current_ratio = 1'h0, i_fast_slew = 1'h0, i_internal_pwm = 1'h1, i_pwm_on = 1'h0;
  logic i_direct_in_pin = 1'h0, i_oc_seen = 1'h0, i_oc_window = 1'h0, i_fault_read = 1'h0;
  logic i_sense_select_a = 1'h0, i_sense_select_b = 1'h0, i_track_hold = 1'h0, seen = 1'h0;
  logic [1:0] load_fault = 2'h0;
  wire logic i_cmp_short_pin, i_cmp_off_open_pin, i_cmp_on_open_pin;
  logic o_channel_on, o_fault_pin_n, o_supply_short_flag, o_off_open_load_flag, o_on_open_load_flag;
  logic o_oc_duration_restart, o_retry_exhausted, o_delatch, o_sense_enable, o_sense_hold, o_sense_sync_pin;
  logic o_high_current_ratio, o_low_oc_threshold;
  logic [2:0] o_read_data;
  logic [3:0] o_retry_count;
  logic [1:0] o_sense_source;
  int n_fail = 0, n_tests = 0, cycles = 0;
  switch_diag #(.ON_OPEN_LOAD_FLAG_PERIOD(50)) i_dut (.*);
  load_model i_load (.i_on(o_channel_on), .i_fault(load_fault), .o_short(i_cmp_short_pin),
    .o_off_open(i_cmp_off_open_pin), .o_on_open(i_cmp_on_open_pin));
  always #2.5 i_clock = ~i_clock;
  task automatic final_report;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic look(input int n);
    cyc(n);
    @(negedge i_clock);
  endtask
  function automatic logic [3:0] flg();
    return {1'h0, o_on_open_load_flag, o_off_open_load_flag, o_supply_short_flag};
  endfunction
  task automatic rd;
    cyc(1);
    i_fault_read <= 1'h1;
    cyc(1);
    i_fault_read <= 1'h0;
    look(3);
  endtask
  task automatic t_off_fault(input int idx);
    logic [3:0] m;
    m = 4'h1 << idx;
    cyc(1);
    load_fault <= m[1:0];
    look(10);
    chk(flg(), m);
    chk({3'h0, o_fault_pin_n}, 4'h0);
    cyc(1);
    load_fault <= 2'h0;
    look(10);
    chk(flg(), m);
    chk({3'h0, o_fault_pin_n}, 4'h1);
    rd;
    chk({1'h0, o_read_data}, m);
    chk(flg(), 4'h0);
    cyc(1);
    i_channel_config_register[6 + idx] <= 1'h1;
    load_fault <= m[1:0];
    look(10);
    chk(flg(), 4'h0);
    cyc(1);
    load_fault <= 2'h0;
    cyc(8);
    i_channel_config_register <= 9'h0;
  endtask
  task automatic t_on_open;
    cyc(1);
    i_pwm_on <= 1'h1;
    cyc(2);
    load_fault <= 2'h2;
    look(10);
    chk(flg(), 4'h4);
    chk({2'h0, o_channel_on, o_fault_pin_n}, 4'h2);
    rd;
    chk(flg(), 4'h4);
    cyc(1);
    load_fault <= 2'h0;
    look(10);
    chk({3'h0, o_fault_pin_n}, 4'h1);
    rd;
    chk(flg(), 4'h0);
    cyc(1);
    load_fault <= 2'h2;
    cyc(10);
    i_pwm_on <= 1'h0;
    cyc(10);
    rd;
    chk({3'h0, o_on_open_load_flag}, 4'h0);
    cyc(1);
    load_fault <= 2'h0;
    cyc(10);
    rd;
  endtask
  task automatic t_low_ratio;
    cyc(1);
    i_low_current_ratio <= 1'h1;
    i_internal_pwm <= 1'h0;
    load_fault <= 2'h2;
    for (int fs = 0; fs < 2; fs++) begin
      cyc(1);
      i_fast_slew <= fs[0];
      i_direct_in_pin <= 1'h1;
      look(10);
      chk({3'h0, o_on_open_load_flag}, 4'h0);
      cyc(1);
      i_direct_in_pin <= 1'h0;
      look(10);
      chk({3'h0, o_on_open_load_flag}, fs[3:0]);
    end
    cyc(1);
    load_fault <= 2'h0;
    rd;
    chk({3'h0, o_on_open_load_flag}, 4'h1);
    cyc(1);
    i_direct_in_pin <= 1'h1;
    cyc(10);
    i_direct_in_pin <= 1'h0;
    cyc(10);
    rd;
    chk({3'h0, o_on_open_load_flag}, 4'h0);
    cyc(1);
    i_channel_config_register[5] <= 1'h1;
    i_direct_in_pin <= 1'h1;
    look(10);
    chk({3'h0, o_channel_on}, 4'h0);
    cyc(1);
    i_direct_in_pin <= 1'h0;
    i_channel_config_register <= 9'h0;
    {i_internal_pwm, i_low_current_ratio, i_fast_slew} <= 3'h4;
    rd;
  endtask
  task automatic retries(input int n);
    repeat (n) begin
      cyc(1);
      i_retry_event <= 1'h1;
      cyc(1);
      i_retry_event <= 1'h0;
    end
    look(2);
  endtask
  task automatic t_retry;
    retries(15);
    chk(o_retry_count, 4'hf);
    chk({3'h0, o_retry_exhausted}, 4'h0);
    retries(1);
    chk({3'h0, o_retry_exhausted}, 4'h1);
    for (int k = 0; k < 3; k++) begin
      retries(2);
      cyc(1);
      {i_sleep_exit, i_failsafe_enter, i_por} <= 3'h1 << k;
      cyc(1);
      {i_sleep_exit, i_failsafe_enter, i_por} <= 3'h0;
      look(2);
      chk(o_retry_count, 4'h0);
    end
    retries(3);
    cyc(1);
    i_retry_sel <= 1'h1;
    look(2);
    chk(o_retry_count, 4'h0);
    cyc(1);
    i_load_motor <= 1'h1;
    retries(2);
    chk(o_retry_count, 4'h2);
    cyc(1);
    i_retry_sel <= 1'h0;
    look(2);
    chk(o_retry_count, 4'h0);
    cyc(1);
    i_retry_sel <= 1'h1;
    retries(2);
    cyc(1);
    i_latch_event <= 1'h1;
    cyc(1);
    i_latch_event <= 1'h0;
    i_unlimited <= 1'h1;
    repeat (6) begin
      @(negedge i_clock);
      seen |= o_delatch;
    end
    chk({3'h0, seen}, 4'h1);
    chk(o_retry_count, 4'h0);
    cyc(1);
    {i_unlimited, i_load_motor, i_retry_sel} <= 3'h0;
  endtask
  task automatic t_sense;
    for (int k = 0; k < 4; k++) begin
      cyc(1);
      {i_sense_select_b, i_sense_select_a} <= k[1:0];
      look(2);
      chk({2'h0, o_sense_source}, k[3:0]);
    end
    cyc(1);
    i_track_hold <= 1'h1;
    look(2);
    chk({1'h0, o_sense_hold, o_sense_enable, o_sense_sync_pin}, 4'h7);
    cyc(1);
    i_track_hold <= 1'h0;
    look(2);
    chk({1'h0, o_sense_hold, o_sense_enable, o_sense_sync_pin}, 4'h1);
    cyc(1);
    i_pwm_on <= 1'h1;
    look(3);
    chk({1'h0, o_sense_hold, o_sense_enable, o_sense_sync_pin}, 4'h2);
    cyc(1);
    i_oc_window <= 1'h1;
    look(2);
    chk({1'h0, o_sense_hold, o_sense_enable, o_sense_sync_pin}, 4'h1);
    cyc(1);
    {i_oc_window, i_pwm_on, i_low_current_ratio} <= 3'h1;
    look(2);
    chk({2'h0, o_high_current_ratio, o_low_oc_threshold}, 4'h1);
  endtask
  task automatic t_pwm_low;
    cyc(1);
    {i_low_current_ratio, i_fast_slew, i_internal_pwm} <= 3'h7;
    load_fault <= 2'h2;
    for (int k = 0; k < 3; k++) begin
      if (k != 1) begin
        cyc(60);
      end
      cyc(1);
      i_pwm_on <= 1'h1;
      cyc(10);
      i_pwm_on <= 1'h0;
      cyc(10);
      load_fault <= 2'h0;
      rd;
      chk({3'h0, o_on_open_load_flag}, {3'h0, k < 2});
    end
    cyc(1);
    load_fault <= 2'h2;
    i_pwm_on <= 1'h1;
    look(120);
    chk({3'h0, o_on_open_load_flag}, 4'h1);
    cyc(1);
    load_fault <= 2'h0;
    i_pwm_on <= 1'h0;
    cyc(10);
    {i_low_current_ratio, i_fast_slew, i_internal_pwm} <= 3'h1;
    rd;
  endtask
  task automatic t_restart;
    for (int oc = 1; oc >= 0; oc--) begin
      cyc(1);
      i_load_motor <= 1'h1;
      i_pwm_on <= 1'h1;
      cyc(2);
      i_oc_seen <= oc[0];
      cyc(1);
      i_oc_seen <= 1'h0;
      cyc(2);
      i_pwm_on <= 1'h0;
      seen = 1'h0;
      repeat (4) begin
        @(negedge i_clock);
        seen |= o_oc_duration_restart;
      end
      chk({3'h0, seen}, {3'h0, !oc[0]});
    end
    cyc(1);
    i_load_motor <= 1'h0;
  endtask
  initial begin
    cyc(16);
    i_nrst <= 1'h1;
    look(4);
    t_off_fault(0);
    t_off_fault(1);
    t_on_open;
    t_low_ratio;
    t_pwm_low;
    t_retry;
    t_restart;
    t_sense;
    final_report;
  end
endmodule
